// >>> hdl/dps_slave.sv
// i2c command slave for a 64-position nonvolatile potentiometer
`timescale 1ns/1ns
`default_nettype none
module dps_slave #(
  parameter int STORE_CYCLES = dps_pkg::STORE_CYC,
  parameter logic [7:0] TOL_BYTE0 = 8'h00,
  parameter logic [7:0] TOL_BYTE1 = 8'h00
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_oe_n,
  input wire dps_pkg::dps_pin_t addr_select_pin_lo,
  input wire dps_pkg::dps_pin_t addr_select_pin_hi,
  output logic [63:0] tap_select,
  output logic [5:0] wiper_setting_register,
  output logic write_protect,
  output logic nvm_busy
);
  // two-flop synchronisers; stage one feeds only stage two
  logic [1:0] scl_s1_r, scl_s1_nxt, scl_s2_r, scl_s2_nxt, scl_d_r, scl_d_nxt;
  always_comb begin
    scl_s1_nxt = {sda_in, scl_in};
    scl_s2_nxt = scl_s1_r;
    scl_d_nxt = scl_s2_r;
  end
  always_ff @(posedge clk) begin
    if (!nrst) begin
      scl_s1_r <= 2'h3;
      scl_s2_r <= 2'h3;
      scl_d_r <= 2'h3;
    end else begin
      scl_s1_r <= scl_s1_nxt;
      scl_s2_r <= scl_s2_nxt;
      scl_d_r <= scl_d_nxt;
    end
  end
  logic scl, sda, scl_rise, scl_fall, start_ev, stop_ev;
  assign scl = scl_s2_r[0];
  assign sda = scl_s2_r[1];
  assign scl_rise = scl & ~scl_d_r[0];
  assign scl_fall = ~scl & scl_d_r[0];
  assign start_ev = scl & scl_d_r[0] & scl_d_r[1] & ~sda;
  assign stop_ev = scl & scl_d_r[0] & ~scl_d_r[1] & sda;

  // address decode: pins caught in the first cycle after reset release, then frozen
  // straps come from outside the clock domain: two flops without reset, so they have
  // settled long before reset lets go and the address is caught
  dps_pkg::dps_pin_t lo_s1_r, lo_s1_nxt, lo_s2_r, lo_s2_nxt;
  dps_pkg::dps_pin_t hi_s1_r, hi_s1_nxt, hi_s2_r, hi_s2_nxt;
  always_comb begin
    lo_s1_nxt = addr_select_pin_lo;
    lo_s2_nxt = lo_s1_r;
    hi_s1_nxt = addr_select_pin_hi;
    hi_s2_nxt = hi_s1_r;
  end
  always_ff @(posedge clk) begin
    lo_s1_r <= lo_s1_nxt;
    lo_s2_r <= lo_s2_nxt;
    hi_s1_r <= hi_s1_nxt;
    hi_s2_r <= hi_s2_nxt;
  end
  logic [1:0] lo_st, hi_st;
  assign lo_st = lo_s2_r.sense_up ? (lo_s2_r.sense_dn ? dps_pkg::PIN_HIGH
                 : dps_pkg::PIN_FLOAT) : dps_pkg::PIN_LOW;
  assign hi_st = hi_s2_r.sense_up ? (hi_s2_r.sense_dn ? dps_pkg::PIN_HIGH
                 : dps_pkg::PIN_FLOAT) : dps_pkg::PIN_LOW;
  logic [6:0] my_addr_r, my_addr_nxt;
  logic addr_ok_r, addr_ok_nxt;
  always_comb begin
    my_addr_nxt = my_addr_r;
    addr_ok_nxt = 1'b1;
    if (!addr_ok_r) begin
      my_addr_nxt = dps_pkg::ADDR_TAB[4'(3 * int'(lo_st) + int'(hi_st))];
    end
  end
  always_ff @(posedge clk) begin
    if (!nrst) begin
      my_addr_r <= 7'h00;
      addr_ok_r <= 1'b0;
    end else begin
      my_addr_r <= my_addr_nxt;
      addr_ok_r <= addr_ok_nxt;
    end
  end

  // protocol engine
  dps_pkg::dps_state_t st_r, st_nxt;
  logic [3:0] bit_r, bit_nxt;
  logic [7:0] sh_r, sh_nxt;
  logic ack_r, ack_nxt;
  logic [2:0] cmd_r, cmd_nxt;
  logic tol_idx_r, tol_idx_nxt;
  logic [5:0] wiper_r, wiper_nxt, nvm_r, nvm_nxt;
  logic nvm_prog_r, nvm_prog_nxt, wp_r, wp_nxt, oe_n_r, oe_n_nxt;
  logic [31:0] busy_cnt_r, busy_cnt_nxt;
  logic [63:0] tap_r, tap_nxt;
  logic [7:0] rd_byte, rx_byte;
  logic nvm_wr_ok;
  assign rx_byte = {sh_r[6:0], sda};
  assign nvm_wr_ok = !wp_r && busy_cnt_r == 32'h0;
  always_comb begin
    unique case (cmd_r)
      dps_pkg::CMD_NVM: rd_byte = {2'h0, nvm_r};
      dps_pkg::CMD_WP: rd_byte = tol_idx_r ? TOL_BYTE1 : TOL_BYTE0;
      default: rd_byte = {2'h0, wiper_r};
    endcase
  end
  always_comb begin
    st_nxt = st_r;
    bit_nxt = bit_r;
    sh_nxt = sh_r;
    ack_nxt = ack_r;
    cmd_nxt = cmd_r;
    tol_idx_nxt = tol_idx_r;
    wiper_nxt = wiper_r;
    nvm_nxt = nvm_r;
    nvm_prog_nxt = nvm_prog_r;
    wp_nxt = wp_r;
    oe_n_nxt = oe_n_r;
    busy_cnt_nxt = (busy_cnt_r != 32'h0) ? busy_cnt_r - 32'h1 : 32'h0;
    if (start_ev) begin
      st_nxt = dps_pkg::ST_ADDR;
      bit_nxt = 4'h0;
      ack_nxt = 1'b0;
      oe_n_nxt = 1'b1;
      tol_idx_nxt = 1'b0;
    end else if (stop_ev) begin
      st_nxt = dps_pkg::ST_IDLE;
      oe_n_nxt = 1'b1;
    end else if (st_r == dps_pkg::ST_RDATA) begin
      // read: bits leave on falling scl; the master's acknowledge is taken on the ninth rise
      if (scl_rise && bit_r == 4'h9) begin
        bit_nxt = 4'h0;
        tol_idx_nxt = ~tol_idx_r;
        if (sda) begin
          st_nxt = dps_pkg::ST_IGNORE;
        end
      end else if (scl_fall) begin
        if (ack_r && oe_n_r) begin
          oe_n_nxt = 1'b0;
        end else if (ack_r || bit_r == 4'h0) begin
          // whole byte latched at once so a later pointer change cannot tear it
          ack_nxt = 1'b0;
          sh_nxt = rd_byte;
          oe_n_nxt = rd_byte[7];
          bit_nxt = 4'h1;
        end else if (bit_r < 4'h8) begin
          oe_n_nxt = sh_r[3'(4'h7 - bit_r)];
          bit_nxt = bit_r + 4'h1;
        end else if (bit_r == 4'h8) begin
          oe_n_nxt = 1'b1; // hand the line over for the master's acknowledge
          bit_nxt = 4'h9;
        end
      end
    end else if (st_r != dps_pkg::ST_IDLE && st_r != dps_pkg::ST_IGNORE) begin
      if (scl_rise && !ack_r) begin
        sh_nxt = rx_byte;
        bit_nxt = bit_r + 4'h1;
        if (bit_r == 4'h7) begin
          bit_nxt = 4'h0;
          ack_nxt = 1'b1;
          unique case (st_r)
            dps_pkg::ST_ADDR: begin
              if (rx_byte[7:1] != my_addr_r) begin
                st_nxt = dps_pkg::ST_IGNORE;
                ack_nxt = 1'b0;
              end else begin
                st_nxt = rx_byte[0] ? dps_pkg::ST_RDATA : dps_pkg::ST_INSTR;
              end
            end
            dps_pkg::ST_INSTR: begin
              cmd_nxt = rx_byte[7:5];
              st_nxt = dps_pkg::ST_WDATA;
              tol_idx_nxt = 1'b0;
              if (rx_byte[7:5] == dps_pkg::CMD_STORE && nvm_wr_ok) begin
                nvm_nxt = wiper_r;
                nvm_prog_nxt = 1'b1;
                busy_cnt_nxt = 32'(STORE_CYCLES);
              end
              if (rx_byte[7:5] == dps_pkg::CMD_RESTORE) begin
                wiper_nxt = nvm_r;
              end
            end
            dps_pkg::ST_WDATA: begin
              unique case (cmd_r)
                dps_pkg::CMD_WIPER: wiper_nxt = rx_byte[5:0];
                dps_pkg::CMD_NVM: begin
                  if (nvm_wr_ok) begin
                    nvm_nxt = rx_byte[5:0];
                    nvm_prog_nxt = 1'b1;
                    busy_cnt_nxt = 32'(STORE_CYCLES);
                  end
                end
                dps_pkg::CMD_WP: wp_nxt = rx_byte[0];
                default: ;
              endcase
            end
            default: ack_nxt = 1'b0; // not reached: read and idle states are handled apart
          endcase
        end
      end else if (scl_fall && ack_r) begin
        // acknowledge: pull low on one fall, release on the next
        if (oe_n_r) begin
          oe_n_nxt = 1'b0;
        end else begin
          oe_n_nxt = 1'b1;
          ack_nxt = 1'b0;
        end
      end
    end
    for (int i = 0; i < dps_pkg::TAPS; i++) begin
      tap_nxt[i] = (wiper_nxt == i[5:0]);
    end
  end
  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_r <= dps_pkg::ST_IDLE;
      bit_r <= 4'h0;
      sh_r <= 8'h00;
      ack_r <= 1'b0;
      cmd_r <= dps_pkg::CMD_WIPER;
      tol_idx_r <= 1'b0;
      wiper_r <= dps_pkg::WIPER_MID;
      nvm_r <= dps_pkg::WIPER_MID;
      nvm_prog_r <= 1'b0;
      wp_r <= 1'b0;
      oe_n_r <= 1'b1;
      busy_cnt_r <= 32'h0;
      tap_r <= 64'h1 << dps_pkg::WIPER_MID;
    end else begin
      st_r <= st_nxt;
      bit_r <= bit_nxt;
      sh_r <= sh_nxt;
      ack_r <= ack_nxt;
      cmd_r <= cmd_nxt;
      tol_idx_r <= tol_idx_nxt;
      wiper_r <= wiper_nxt;
      nvm_r <= nvm_nxt;
      nvm_prog_r <= nvm_prog_nxt;
      wp_r <= wp_nxt;
      oe_n_r <= oe_n_nxt;
      busy_cnt_r <= busy_cnt_nxt;
      tap_r <= tap_nxt;
    end
  end
  assign sda_oe_n = oe_n_r;
  assign tap_select = tap_r;
  assign wiper_setting_register = wiper_r;
  assign write_protect = wp_r;
  always_ff @(posedge clk) begin
    if (!nrst) nvm_busy <= 1'b0;
    else nvm_busy <= (busy_cnt_nxt != 32'h0);
  end

  property p_onehot;
    @(posedge clk) disable iff (!nrst) $onehot(tap_select) && tap_select[wiper_r];
  endproperty
  a_onehot: assert property (p_onehot) else $error("tap select not one-hot");
  property p_stop_idle;
    @(posedge clk) disable iff (!nrst) stop_ev && !start_ev |=> st_r == dps_pkg::ST_IDLE;
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("stop not honoured");
  property p_ignore_quiet;
    @(posedge clk) disable iff (!nrst) st_r == dps_pkg::ST_IGNORE |-> sda_oe_n;
  endproperty
  a_ignore_quiet: assert property (p_ignore_quiet) else $error("drove sda while ignoring");
  property p_sda_on_fall;
    @(posedge clk) disable iff (!nrst) $changed(oe_n_r) && !stop_ev && !start_ev
      |-> $past(scl_fall);
  endproperty
  a_sda_on_fall: assert property (p_sda_on_fall) else $error("sda moved off falling scl");
  property p_wp_keep;
    @(posedge clk) disable iff (!nrst) wp_r |=> $stable(nvm_r);
  endproperty
  a_wp_keep: assert property (p_wp_keep) else $error("protected memory changed");
  property p_busy;
    @(posedge clk) disable iff (!nrst) $rose(nvm_prog_r) |=> nvm_busy [*8];
  endproperty
  a_busy: assert property (p_busy) else $error("store time too short");
  property p_wp_nostore;
    @(posedge clk) disable iff (!nrst) cmd_r == dps_pkg::CMD_WP |-> $stable(wiper_r) || start_ev
      || $past(start_ev);
  endproperty
  a_wp_nostore: assert property (p_wp_nostore) else $error("protect cmd moved wiper");
  property p_addr_fixed;
    @(posedge clk) disable iff (!nrst) addr_ok_r |=> $stable(my_addr_r);
  endproperty
  a_addr_fixed: assert property (p_addr_fixed) else $error("address changed after power-up");
endmodule
`default_nettype wire

// >>> hdl/dps_pkg.sv
// constants and types for the potentiometer i2c command slave
`default_nettype none
package dps_pkg;
  localparam int WIPER_W = 6;
  localparam int TAPS = 64;
  localparam logic [5:0] WIPER_MID = 6'h20;
  localparam logic [2:0] CMD_WIPER = 3'h0;
  localparam logic [2:0] CMD_NVM = 3'h1;
  localparam logic [2:0] CMD_WP = 3'h2;
  localparam logic [2:0] CMD_NOP = 3'h4;
  localparam logic [2:0] CMD_RESTORE = 3'h5;
  localparam logic [2:0] CMD_STORE = 3'h6;
  localparam int CLK_HZ = 25000000;
  localparam int STORE_MS = 26;
  localparam int STORE_CYC = STORE_MS * (CLK_HZ / 1000);
  // address table index = 3*pin_lo_state + pin_hi_state (0 low, 1 float, 2 high)
  localparam logic [6:0] ADDR_TAB [9] = '{7'h18, 7'h19, 7'h1a, 7'h29, 7'h2a, 7'h2b,
                                          7'h4c, 7'h4d, 7'h4e};
  localparam logic [1:0] PIN_LOW = 2'h0;
  localparam logic [1:0] PIN_FLOAT = 2'h1;
  localparam logic [1:0] PIN_HIGH = 2'h2;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_INSTR = 3'h2,
    ST_WDATA = 3'h3,
    ST_RDATA = 3'h4,
    ST_IGNORE = 3'h5
  } dps_state_t;
  // one three-state select pin as seen by the pad: drive sense and pulled sense
  typedef struct packed {
    logic sense_up;
    logic sense_dn;
  } dps_pin_t;
endpackage
`default_nettype wire

// >>> verification/dps_i2c_master.sv
// behavioural i2c bus master that drives the slave's scl and sda pins
`timescale 1ns/1ns
`default_nettype none
module dps_i2c_master (
  output logic scl,
  output logic sda_m,
  input wire logic sda
);
  localparam int Q = 80; // quarter of the 320 ns bus period
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  // start or repeated start: sda falls while scl is high
  task automatic start();
    sda_m = 1'b1;
    #Q scl = 1'b1;
    #Q sda_m = 1'b0;
    #Q scl = 1'b0;
    #Q;
  endtask
  // sda pulled low in the low phase, so a read that ended in no acknowledge closes cleanly
  task automatic stop();
    sda_m = 1'b0;
    #Q scl = 1'b1;
    #Q sda_m = 1'b1;
    #Q;
  endtask
  // eight bits msb first, then the ninth clock; a released line reads high via the pull-up
  task automatic xfer(input logic [7:0] d, input logic ackm, output logic [7:0] r,
                      output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_m = d[i];
      #Q scl = 1'b1;
      #Q r[i] = sda;
      #Q scl = 1'b0;
      #Q;
    end
    sda_m = ackm;
    #Q scl = 1'b1;
    #Q ack = sda;
    #Q scl = 1'b0;
    #Q;
  endtask
endmodule
`default_nettype wire

// >>> verification/test_dps_slave.sv
// self-checking bench for the potentiometer i2c command slave
`timescale 1ns/1ns
`default_nettype none
module test_dps_slave;
  localparam int STORE_N = 40; // short nonvolatile write time to keep the run brief
  localparam logic [7:0] TOL0 = 8'h5c;
  localparam logic [7:0] TOL1 = 8'ha3;
  localparam logic [7:0] AW = 8'h54; // both pins floating: address 0101010, write
  localparam logic [7:0] AR = 8'h55;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  wire scl;
  wire sda_m;
  wire sda;
  wire sda_oe_n;
  wire [63:0] tap_select;
  wire [5:0] wiper;
  wire wp;
  wire busy;
  dps_pkg::dps_pin_t pin_lo = '{sense_up: 1'b1, sense_dn: 1'b0};
  dps_pkg::dps_pin_t pin_hi = '{sense_up: 1'b1, sense_dn: 1'b0};
  int error_cnt = 0;
  int check_count = 0;
  int cyc = 0;
  logic oe_q = 1'b1;
  logic scl_q = 1'b1;
  assign sda = sda_m & sda_oe_n; // open drain with pull-up
  dps_i2c_master dps_i2c_master_i (.scl(scl), .sda_m(sda_m), .sda(sda));
  dps_slave #(.STORE_CYCLES(STORE_N), .TOL_BYTE0(TOL0), .TOL_BYTE1(TOL1)) dps_slave_i (
    .clk(clk), .nrst(nrst), .scl_in(scl), .sda_in(sda), .sda_oe_n(sda_oe_n),
    .addr_select_pin_lo(pin_lo), .addr_select_pin_hi(pin_hi), .tap_select(tap_select),
    .wiper_setting_register(wiper), .write_protect(wp), .nvm_busy(busy));
  initial begin
    forever #20 clk = ~clk;
  end
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // send a byte and check the acknowledge level seen on the ninth clock
  task automatic sb(input logic [7:0] d, input logic ea);
    logic [7:0] r;
    logic a;
    dps_i2c_master_i.xfer(d, 1'b1, r, a);
    chk(64'(a), 64'(ea));
  endtask
  task automatic rb(input logic [7:0] e, input logic na);
    logic [7:0] r;
    logic a;
    dps_i2c_master_i.xfer(8'hff, na, r, a);
    chk(64'(r), 64'(e));
  endtask
  task automatic cmd(input logic [7:0] ins, input logic [7:0] d, input logic has_d);
    dps_i2c_master_i.start();
    sb(AW, 1'b0);
    sb(ins, 1'b0);
    if (has_d) sb(d, 1'b0);
    dps_i2c_master_i.stop();
  endtask
  // pointer setup, repeated start, one byte closed by no acknowledge
  task automatic rd(input logic [7:0] ins, input logic [7:0] e);
    dps_i2c_master_i.start();
    sb(AW, 1'b0);
    sb(ins, 1'b0);
    dps_i2c_master_i.start();
    sb(AR, 1'b0);
    rb(e, 1'b1);
    dps_i2c_master_i.stop();
  endtask
  // bounded wait, the write time is only a few dozen cycles here
  task automatic wait_idle();
    int n;
    n = 0;
    while (busy === 1'b1 && n < STORE_N + 20) begin
      @(posedge clk);
      n++;
    end
    chk(64'(busy), 64'h0);
  endtask
  // sda must hold still while scl is high, outside start and stop the slave never makes
  always @(posedge clk) begin
    scl_q <= scl;
    oe_q <= sda_oe_n;
    if (nrst && scl_q && scl && sda_oe_n !== oe_q) chk(64'(sda_oe_n), 64'(oe_q));
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      error_cnt++;
      conclude();
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    #1 nrst = 1'b1;
    repeat (6) @(posedge clk);
    #1;
    chk(64'(wiper), 64'h20);
    chk(tap_select, 64'h0000000100000000);
    chk({62'h0, wp, busy}, 64'h0);
    dps_i2c_master_i.start();
    sb(AW, 1'b0);
    sb(8'h00, 1'b0);
    sb(8'hc5, 1'b0);
    chk(64'(wiper), 64'h05);
    sb(8'h3a, 1'b0);
    chk(64'(wiper), 64'h3a);
    dps_i2c_master_i.stop();
    chk(tap_select, 64'h0400000000000000);
    dps_i2c_master_i.start();
    sb(8'h30, 1'b1);
    sb(8'h00, 1'b1);
    sb(8'h11, 1'b1);
    dps_i2c_master_i.stop();
    chk(64'(wiper), 64'h3a);
    rd(8'h00, 8'h3a);
    dps_i2c_master_i.start();
    sb(AR, 1'b0);
    rb(8'h3a, 1'b0);
    rb(8'h3a, 1'b1);
    dps_i2c_master_i.stop();
    cmd(8'hc0, 8'h00, 1'b0);
    chk(64'(busy), 64'h1);
    wait_idle();
    cmd(8'h00, 8'h07, 1'b1);
    chk(64'(wiper), 64'h07);
    cmd(8'ha0, 8'h00, 1'b0);
    chk(64'(wiper), 64'h3a);
    rd(8'h20, 8'h3a);
    cmd(8'h40, 8'h01, 1'b1);
    chk({57'h0, wp, wiper}, 64'h7a);
    dps_i2c_master_i.start();
    sb(AR, 1'b0);
    rb(TOL0, 1'b0);
    rb(TOL1, 1'b1);
    dps_i2c_master_i.stop();
    cmd(8'h20, 8'h15, 1'b1);
    chk(64'(busy), 64'h0);
    cmd(8'hc0, 8'h00, 1'b0);
    chk(64'(busy), 64'h0);
    rd(8'h20, 8'h3a);
    cmd(8'h40, 8'hfe, 1'b1);
    chk(64'(wp), 64'h0);
    cmd(8'h20, 8'h15, 1'b1);
    chk(64'(busy), 64'h1);
    wait_idle();
    rd(8'h20, 8'h15);
    cmd(8'h80, 8'h00, 1'b0);
    chk(64'(wiper), 64'h3a);
    // second power-up with other strap levels: low select low, high select high gives 0011010
    @(posedge clk);
    #1 nrst = 1'b0;
    pin_lo = '{sense_up: 1'b0, sense_dn: 1'b0};
    pin_hi = '{sense_up: 1'b1, sense_dn: 1'b1};
    repeat (10) @(posedge clk);
    #1 nrst = 1'b1;
    repeat (6) @(posedge clk);
    #1;
    chk(64'(wiper), 64'h20);
    dps_i2c_master_i.start();
    sb(AW, 1'b1);
    dps_i2c_master_i.stop();
    dps_i2c_master_i.start();
    sb(8'h34, 1'b0);
    sb(8'h00, 1'b0);
    sb(8'h11, 1'b0);
    dps_i2c_master_i.stop();
    chk(64'(wiper), 64'h11);
    conclude();
  end
endmodule
`default_nettype wire
